//--- shared/mic_pkg.sv
// Constants, register map and carrier types of the microcontroller interrupt controller.
// Function
// [RULE1] Seven request lines: pin pair A, pin pair B, converter, three timers, comparator.
// [RULE2] Each request line has its own enable bit.
// [RULE3] Hardware sets request flags; only a software write to the flag register clears them.
// [RULE4] Edge select picks rising, falling or both edges per source.
// [RULE5] Global enable gates all lines; enable and disable instructions set and clear it.
// [RULE6] Flags still set while the line's enable bit is zero.
// [RULE7] Interrupt stack lives in data memory at the stack pointer.
// [RULE8] Software keeps stack pointer bit 0 at zero.
// [RULE9] On entry the program counter is written to stack memory at the stack pointer.
// [RULE10] On entry the stack pointer grows by two after the save.
// [RULE11] On entry the global enable is cleared, blocking nesting.
// [RULE12] After entry the next fetch comes from the fixed vector address.
// [RULE13] The request flag register is readable to identify sources.
// [RULE14] Return reloads the program counter from stack memory at the stack pointer.
// [RULE15] Return decrements the stack pointer by two.
// [RULE16] Return sets the global enable and resumes the interrupted instruction.
// [RULE17] Push and pop instructions move accumulator and flags to and from the stack.
// [RULE18] Software reserves two stack bytes per nesting level and per push.
// [RULE19] Software enables digital input on pins used as external sources.
// [RULE20] Taken only when flag, line enable and global enable are set, at instruction boundary.
package mic_pkg;
  localparam int NUM_LINES = 7;
  localparam int PC_W = 16;
  localparam int SP_W = 8;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 16'h0010;
  localparam logic [SP_W-1:0] SP_STEP = 8'h02;
  localparam logic [SP_W-1:0] SP_RESET = 8'h00;
  localparam logic [SP_W-1:0] SP_ONE = 8'h01;
  // Line positions inside flag and enable registers.
  localparam int LN_PIN_A = 0;
  localparam int LN_PIN_B = 1;
  localparam int LN_CONV = 2;
  localparam int LN_T16 = 3;
  localparam int LN_CMP = 4;
  localparam int LN_T8A = 5;
  localparam int LN_T8B = 6;
  // Wishbone word offsets (byte addresses).
  localparam logic [3:0] ADDR_ENABLE = 4'h0;
  localparam logic [3:0] ADDR_FLAGS = 4'h4;
  localparam logic [3:0] ADDR_EDGE = 4'h8;
  localparam logic [3:0] ADDR_STACK = 4'hC;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [13:0] EDGE_RESET = 14'h0000;
  // Edge select codes, two bits per line.
  localparam logic [1:0] EDGE_BOTH = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  typedef enum logic [2:0] {
    MIC_OP_NONE, MIC_OP_ENGINT, MIC_OP_DISGINT, MIC_OP_RETI, MIC_OP_PUSHAF, MIC_OP_POPAF
  } mic_op_t;

  // Request from the core sequencer at an instruction boundary.
  typedef struct packed {
    logic valid;
    mic_op_t op;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] acc_flag;
  } mic_core_req_t;

  // Data memory port toward the stack.
  typedef struct packed {
    logic req;
    logic we;
    logic [SP_W-1:0] addr;
    logic [PC_W-1:0] wdata;
  } mic_mem_req_t;
endpackage : mic_pkg

//--- design/mic_intc.sv
// Interrupt controller: flags, enables, global enable, stack entry and return sequencing.
`timescale 1ns/1ps
`default_nettype none
module mic_intc (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [6:0] src_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire mic_pkg::mic_core_req_t core_req_i,
  output logic core_ack_o,
  output logic core_pc_load_o,
  output logic [15:0] core_pc_o,
  output logic [15:0] core_acc_flag_o,
  output logic core_acc_flag_vld_o,
  output mic_pkg::mic_mem_req_t mem_req_o,
  input wire logic [15:0] mem_rdata_i,
  input wire logic mem_rvalid_i,
  output logic global_en_o
);
  import mic_pkg::*;

  typedef enum {ST_IDLE, ST_PUSH, ST_POPRD, ST_POPWAIT} mic_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Source synchronisers and edge detection.
  logic [NUM_LINES-1:0] sync1_reg, sync2_reg, prev_reg, hit;
  logic [NUM_LINES-1:0] flags_reg, flags_next, enable_reg;
  logic [2*NUM_LINES-1:0] edge_reg;
  logic global_en_reg;
  logic [SP_W-1:0] sp_reg;
  mic_state_t state_reg;
  logic wb_hit, wb_wr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= src_i;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_edge
      logic rise, fall;
      logic [1:0] sel;
      assign rise = sync2_reg[gi] & ~prev_reg[gi];
      assign fall = ~sync2_reg[gi] & prev_reg[gi];
      assign sel = edge_reg[2*gi +: 2];
      // Code 3 is treated as both edges so no setting silently disables a line.
      assign hit[gi] = (sel == EDGE_RISE) ? rise : (sel == EDGE_FALL) ? fall : (rise | fall); // [RULE4] [RULE1]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait-free cycle to ack.
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_hit & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= '0;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          ADDR_ENABLE: wb_dat_o <= {25'h0000000, enable_reg};
          ADDR_FLAGS: wb_dat_o <= {25'h0000000, flags_reg}; // [RULE13]
          ADDR_EDGE: wb_dat_o <= {18'h00000, edge_reg};
          ADDR_STACK: wb_dat_o <= {23'h000000, global_en_reg, sp_reg};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_reg <= EN_RESET[NUM_LINES-1:0];
      edge_reg <= EDGE_RESET;
    end else begin
      if (wb_wr && wb_adr_i == ADDR_ENABLE) enable_reg <= wb_dat_i[NUM_LINES-1:0]; // [RULE2]
      if (wb_hit && wb_we_i && wb_adr_i == ADDR_EDGE) begin
        if (wb_sel_i[0]) edge_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) edge_reg[13:8] <= wb_dat_i[13:8];
      end
    end
  end

  // A write stores the written bits, so writing zero clears; a same-cycle edge still sets.
  always_comb begin
    flags_next = flags_reg;
    if (wb_wr && wb_adr_i == ADDR_FLAGS) flags_next = wb_dat_i[NUM_LINES-1:0]; // [RULE3]
    flags_next = flags_next | hit; // [RULE6]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) flags_reg <= '0;
    else flags_reg <= flags_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Entry, return and push/pop sequencer.
  logic take;
  logic core_hit;
  assign take = global_en_reg & |(flags_reg & enable_reg); // [RULE20] [RULE5]
  // The core drops valid only at the edge where it sees ack, so a request is not taken twice.
  assign core_hit = core_req_i.valid & ~core_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      global_en_reg <= 1'b0;
      sp_reg <= SP_RESET;
      core_ack_o <= 1'b0;
      core_pc_load_o <= 1'b0;
      core_pc_o <= '0;
      core_acc_flag_o <= '0;
      core_acc_flag_vld_o <= 1'b0;
      mem_req_o <= '0;
      global_en_o <= 1'b0;
    end else begin
      core_ack_o <= 1'b0;
      core_pc_load_o <= 1'b0;
      core_acc_flag_vld_o <= 1'b0;
      mem_req_o <= '0;
      if (wb_wr && wb_adr_i == ADDR_STACK) sp_reg <= wb_dat_i[SP_W-1:0];
      case (state_reg)
        ST_IDLE: begin
          if (core_hit) begin
            if (take) begin
              mem_req_o <= '{req: 1'b1, we: 1'b1, addr: sp_reg, wdata: core_req_i.pc}; // [RULE9] [RULE7]
              global_en_reg <= 1'b0; // [RULE11]
              global_en_o <= 1'b0;
              core_pc_o <= VECTOR_ADDR; // [RULE12]
              core_pc_load_o <= 1'b1;
              core_ack_o <= 1'b1;
              state_reg <= ST_PUSH;
            end else begin
              case (core_req_i.op)
                MIC_OP_ENGINT: begin
                  global_en_reg <= 1'b1; // [RULE5]
                  global_en_o <= 1'b1;
                  core_ack_o <= 1'b1;
                end
                MIC_OP_DISGINT: begin
                  global_en_reg <= 1'b0; // [RULE5]
                  global_en_o <= 1'b0;
                  core_ack_o <= 1'b1;
                end
                MIC_OP_PUSHAF: begin
                  mem_req_o <= '{req: 1'b1, we: 1'b1, addr: sp_reg, wdata: core_req_i.acc_flag}; // [RULE17]
                  state_reg <= ST_PUSH;
                  core_ack_o <= 1'b1;
                end
                MIC_OP_RETI, MIC_OP_POPAF: begin
                  sp_reg <= sp_reg - SP_STEP; // [RULE15]
                  mem_req_o <= '{req: 1'b1, we: 1'b0, addr: sp_reg - SP_STEP, wdata: '0}; // [RULE14]
                  state_reg <= ST_POPWAIT;
                end
                default: core_ack_o <= core_req_i.valid;
              endcase
            end
          end
        end
        ST_PUSH: begin
          sp_reg <= sp_reg + SP_STEP; // [RULE10]
          state_reg <= ST_IDLE;
        end
        ST_POPWAIT: begin
          if (mem_rvalid_i) begin
            core_ack_o <= 1'b1;
            state_reg <= ST_IDLE;
            if (core_req_i.op == MIC_OP_RETI) begin
              core_pc_o <= mem_rdata_i; // [RULE14] [RULE16]
              core_pc_load_o <= 1'b1;
              global_en_reg <= 1'b1; // [RULE16]
              global_en_o <= 1'b1;
            end else begin
              core_acc_flag_o <= mem_rdata_i; // [RULE17]
              core_acc_flag_vld_o <= 1'b1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_flag_set_wins: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
    hit[0] |=> flags_reg[0]) else $error("edge did not set flag");
  chk_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    (flags_reg[1] && !(wb_wr && wb_adr_i == ADDR_FLAGS)) |=> flags_reg[1]) else $error("flag lost");
  chk_entry_vector: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
    (state_reg == ST_IDLE && core_hit && take) |=> core_pc_load_o && core_pc_o == VECTOR_ADDR)
    else $error("no vector");
  chk_entry_gie_off: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
    (state_reg == ST_IDLE && core_hit && take) |=> !global_en_reg) else $error("gie still set");
  sequence s_entry;
    state_reg == ST_IDLE && core_hit && take && !(wb_wr && wb_adr_i == ADDR_STACK);
  endsequence
  chk_entry_sp_up: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
    s_entry |=> ##1 sp_reg == $past(sp_reg, 2) + SP_STEP) else $error("sp not plus two");
  chk_entry_save: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
    s_entry |=> mem_req_o.req && mem_req_o.we && mem_req_o.addr == $past(sp_reg)) else $error("pc not saved");
  chk_no_take_gie: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE20]
    (state_reg == ST_IDLE && core_hit && !global_en_reg) |=> !core_pc_load_o) else $error("take without gie");
  chk_reti_gie: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
    (state_reg == ST_POPWAIT && mem_rvalid_i && core_req_i.op == MIC_OP_RETI) |=> global_en_reg && core_pc_load_o)
    else $error("reti incomplete");
  chk_reti_sp_down: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE15]
    (state_reg == ST_IDLE && core_hit && !take && core_req_i.op == MIC_OP_RETI
     && !(wb_wr && wb_adr_i == ADDR_STACK)) |=> sp_reg == $past(sp_reg) - SP_STEP) else $error("sp not minus two");
endmodule : mic_intc
`default_nettype wire

//--- tb/mic_mem_model.sv
// Data memory stand-in for the stack port, answering reads promptly and slowly in turn.
`timescale 1ns/1ps
`default_nettype none
module mic_mem_model (
  input wire logic clk_i,
  input wire mic_pkg::mic_mem_req_t mem_req_i,
  output logic [15:0] mem_rdata_o,
  output logic mem_rvalid_o
);
  import mic_pkg::*;
  logic [15:0] mem_reg [0:255];
  logic [7:0] raddr_reg;
  logic [1:0] wait_reg;
  logic slow_reg;
  initial begin
    mem_rvalid_o = 1'b0;
    mem_rdata_o = 16'hA5A5;
    wait_reg = 2'h0;
    slow_reg = 1'b0;
  end
  // Read data toggles every idle cycle so a stale sample never passes for the answer.
  always @(posedge clk_i) begin
    mem_rvalid_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (mem_req_i.req && mem_req_i.we) begin
      mem_reg[mem_req_i.addr] <= mem_req_i.wdata;
    end
    if (mem_req_i.req && !mem_req_i.we) begin
      raddr_reg <= mem_req_i.addr;
      wait_reg <= slow_reg ? 2'h3 : 2'h1;
      slow_reg <= ~slow_reg;
    end else if (wait_reg == 2'h1) begin
      mem_rvalid_o <= 1'b1;
      mem_rdata_o <= mem_reg[raddr_reg];
      wait_reg <= 2'h0;
    end else if (wait_reg != 2'h0) begin
      wait_reg <= wait_reg - 2'h1;
    end
  end
endmodule : mic_mem_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench of the interrupt controller with a data memory stand-in.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mic_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [6:0] src_i = 7'h00;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_ack_o;
  mic_core_req_t core_req_i = '0;
  logic core_ack_o, core_pc_load_o, core_acc_flag_vld_o, global_en_o, mem_rvalid_i;
  logic [15:0] core_pc_o, core_acc_flag_o, mem_rdata_i, pc, af, pco, afo;
  mic_mem_req_t mem_req_o;
  mic_mem_req_t last_wr = '0;
  logic [31:0] rd;
  logic [7:0] spv;
  logic ld, vld;
  logic [1:0] codes [3];
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 22;
  always #5 clk_i = ~clk_i;
  mic_intc i_mic_intc (.clk_i(clk_i), .rst_i(rst_i), .src_i(src_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .core_req_i(core_req_i), .core_ack_o(core_ack_o), .core_pc_load_o(core_pc_load_o),
    .core_pc_o(core_pc_o), .core_acc_flag_o(core_acc_flag_o), .core_acc_flag_vld_o(core_acc_flag_vld_o),
    .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i), .mem_rvalid_i(mem_rvalid_i), .global_en_o(global_en_o));
  mic_mem_model i_mic_mem_model (.clk_i(clk_i), .mem_req_i(mem_req_o), .mem_rdata_o(mem_rdata_i),
    .mem_rvalid_o(mem_rvalid_i));
  always @(negedge clk_i) if (mem_req_o.req && mem_req_o.we) last_wr = mem_req_o;
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task wb(input logic [3:0] adr, input logic we, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) check(32'h0, 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task core(input mic_op_t op, input logic [15:0] pcv = 16'h0, input logic [15:0] afv = 16'h0);
    int n;
    n = 0;
    @(posedge clk_i);
    core_req_i <= '{1'b1, op, pcv, afv};
    do begin
      @(posedge clk_i);
      n++;
    end while (core_ack_o !== 1'b1 && n < 20);
    if (n >= 20) check(32'h0, 32'h1);
    ld = core_pc_load_o;
    pco = core_pc_o;
    vld = core_acc_flag_vld_o;
    afo = core_acc_flag_o;
    core_req_i <= '0;
  endtask : core
  // The sources pass two synchronising stages, so five edges leave margin for the flag.
  task settle(input logic [6:0] v);
    @(posedge clk_i);
    src_i <= v;
    repeat (5) @(posedge clk_i);
  endtask : settle
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
  initial begin
    codes = '{EDGE_RISE, EDGE_FALL, EDGE_BOTH};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(ADDR_STACK, 1'b0, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wb(ADDR_EDGE, 1'b1, {18'h0, {7{codes[i]}}});
      wb(ADDR_FLAGS, 1'b1, 32'h0);
      settle(7'h7F);
      wb(ADDR_FLAGS, 1'b0, 32'h0);
      check(rd, (codes[i] == EDGE_FALL) ? 32'h0 : 32'h7F);
      settle(7'h00);
      wb(4'h2, 1'b1, 32'h0);
      wb(ADDR_FLAGS, 1'b0, 32'h0);
      check(rd, 32'h7F);
    end
    for (int ln = 0; ln < 7; ln++) begin
      pc = 16'($random(seed));
      af = 16'($random(seed));
      spv = 8'($random(seed)) & 8'h7C;
      wb(ADDR_STACK, 1'b1, {24'h0, spv});
      wb(ADDR_FLAGS, 1'b1, 32'h0);
      wb(ADDR_ENABLE, 1'b1, {25'h0, ~(7'h01 << ln)});
      core(MIC_OP_ENGINT);
      check(global_en_o, 32'h1);
      settle(src_i ^ (7'h01 << ln));
      wb(ADDR_FLAGS, 1'b0, 32'h0);
      check(rd, {25'h0, 7'h01 << ln});
      core(MIC_OP_ENGINT);
      check(ld, 32'h0);
      wb(ADDR_ENABLE, 1'b1, {25'h0, 7'h01 << ln});
      core(MIC_OP_ENGINT, pc, af);
      check({ld, pco}, {1'b1, VECTOR_ADDR});
      check({last_wr.addr, last_wr.wdata}, {spv, pc});
      wb(ADDR_STACK, 1'b0, 32'h0);
      check(rd, {24'h0, spv + 8'h02});
      wb(ADDR_FLAGS, 1'b1, 32'h0);
      wb(ADDR_FLAGS, 1'b0, 32'h0);
      check(rd, 32'h0);
      core(MIC_OP_PUSHAF, pc, af);
      check({last_wr.addr, last_wr.wdata}, {spv + 8'h02, af});
      core(MIC_OP_POPAF);
      check({vld, afo}, {1'b1, af});
      core(MIC_OP_RETI);
      check({ld, pco}, {1'b1, pc});
      wb(ADDR_STACK, 1'b0, 32'h0);
      check(rd, {23'h0, 1'b1, spv});
      core(MIC_OP_DISGINT);
      check(global_en_o, 32'h0);
    end
    results();
  end
endmodule : testbench
`default_nettype wire
